// [kspu_check.sv]
// Policy decision for one command against one slot, purely combinational.
// Assumes the requester holds the inputs stable for the cycle it samples the answer.
`timescale 1ns/100ps
module kspu_check (
  kspu_chk_if.chk c
);
  import kspu_pkg::*;
  logic priv;
  logic pub;
  logic ecc;
  assign priv = c.policy[POL_PRIV_BIT];
  assign pub = c.policy[POL_PUB_BIT];
  assign ecc = c.policy[POL_TYPE_LSB +: 3] == KT_P256;
  // Validity control lives only on non-private slots in the upper half
  assign c.vctl = !priv && pub && (c.slot >= VCTL_FIRST_SLOT);
  assign c.nib_valid = c.nibble == NIB_VALID;

  always_comb begin
    c.allowed = 1'b0;
    unique case (c.op)
      OP_SIGN: c.allowed = priv && ecc && (c.temp_src ? c.read_key[RK_TEMP_BIT] : c.read_key[RK_EXT_BIT]);
      OP_KEYGEN, OP_ECDH: c.allowed = priv && ecc;
      OP_PRIV_WRITE: c.allowed = priv;
      OP_VERIFY: c.allowed = !priv && ecc && (!c.vctl || c.validate || c.nib_valid);
      OP_MAC_CHECK, OP_KEY_DERIVE, OP_MAC, OP_HMAC: c.allowed = !priv;
      OP_DIGEST: c.allowed = !priv;
      OP_SLOT_WRITE, OP_INFO: c.allowed = !priv;
      default: c.allowed = 1'b0;
    endcase
  end

  // Random generation returns the new public key whatever public_info_bit says
  assign c.pub_out = c.allowed && (c.op == OP_KEYGEN) && (c.rand_gen || pub);

  a_priv_only: assert property (@(posedge c.clk) disable iff (c.srst)
    priv && !is_priv_op(c.op) |-> !c.allowed) else $error("private slot accepted a foreign command");
  a_nonpriv_deny: assert property (@(posedge c.clk) disable iff (c.srst)
    !priv && is_priv_op(c.op) |-> !c.allowed) else $error("private command accepted on plain slot");
  a_sign_gate: assert property (@(posedge c.clk) disable iff (c.srst)
    c.op == OP_SIGN && c.allowed |-> (c.temp_src ? c.read_key[1] : c.read_key[0]))
    else $error("sign allowed without read key permission");
  a_ecc_type: assert property (@(posedge c.clk) disable iff (c.srst)
    (c.op inside {OP_SIGN, OP_KEYGEN, OP_ECDH, OP_VERIFY}) && c.allowed |-> c.policy[4:2] == 3'b100)
    else $error("ECC command allowed on non-ECC slot");
  a_sha_priv: assert property (@(posedge c.clk) disable iff (c.srst)
    is_sha_op(c.op) && priv |-> !c.allowed) else $error("SHA command allowed on private slot");
  a_digest_rule: assert property (@(posedge c.clk) disable iff (c.srst)
    c.op == OP_DIGEST |-> c.allowed == !priv) else $error("digest permission wrong");
  a_pub_out: assert property (@(posedge c.clk) disable iff (c.srst)
    c.pub_out && !c.rand_gen |-> priv && pub) else $error("public key produced while hidden");
  a_vctl_slot: assert property (@(posedge c.clk) disable iff (c.srst)
    c.vctl |-> c.slot >= 4'h8 && !priv) else $error("validity control outside slots 8 to 15");
  a_verify_free: assert property (@(posedge c.clk) disable iff (c.srst)
    c.op == OP_VERIFY && !priv && ecc && !pub |-> c.allowed) else $error("unchecked verify refused");
endmodule

// [kspu_chk_if.sv]
// Carrier between the register file and the policy decision logic.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface kspu_chk_if (
  input wire logic clk,
  input wire logic srst
);
  import kspu_pkg::*;
  logic [15:0] policy;
  logic [1:0] read_key;
  logic [SLOT_W-1:0] slot;
  kspu_op_t op;
  logic temp_src;
  logic rand_gen;
  logic validate;
  logic [3:0] nibble;
  logic allowed;
  logic pub_out;
  logic vctl;
  logic nib_valid;
  modport req (input clk, srst, allowed, pub_out, vctl, nib_valid,
               output policy, read_key, slot, op, temp_src, rand_gen, validate, nibble);
  modport chk (input clk, srst, policy, read_key, slot, op, temp_src, rand_gen, validate, nibble,
               output allowed, pub_out, vctl, nib_valid);
endinterface

// [kspu_host.sv]
// Avalon-MM host model that issues register accesses to the policy checker.
// Assumes each task is entered just after a rising edge of sys_clk.
`timescale 1ns/100ps
module kspu_host (
  input wire logic sys_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end

  // Hold the request until waitrequest is sampled low; idle lines show inverted values
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
    @(posedge sys_clk);
  endtask
endmodule

// [kspu_pkg.sv]
// Constants, register map and command codes of the key slot usage policy checker.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one aligned word per register.
// Notes on behaviour
// - Private slot gives public key only if public_info_bit set or key generation is random
// - Validity control: slots 8-15, verify only
// - Public_info_bit clear: verify uses key unchecked
// - Validity-controlled slot write forces nibble to 0xA
// - Controlled verify needs nibble 0x5; validation writes it
// - Sign and info report slot validity state
// - Non-private slot refuses sign, keygen, ECDH, private write
// - Private slot allows only sign, keygen, ECDH, private write
// - Read_key_field bits gate external and internal signing
// - Validity nibble kept in storage beside the key
// - Random key generation ignores public_info_bit
// - ECC commands need legal ECC key type
// - SHA commands on private ECC slot return error
// - Digest generation allowed except on private slots
// - Key type 100 is P256, 111 non-ECC, rest reserved
// - Public_info_bit sits at bit 1 of policy word
package kspu_pkg;
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam logic [7:0] OFS_POLICY = 8'h00;
  localparam logic [7:0] OFS_ACCESS = 8'h40;
  localparam logic [7:0] OFS_NIBBLE = 8'h80;
  localparam logic [7:0] OFS_CMD = 8'hC0;
  localparam logic [7:0] OFS_RESULT = 8'hC4;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hC8;
  localparam logic [7:0] OFS_IRQ_CLR = 8'hCC;
  localparam logic [7:0] OFS_IRQ_EN = 8'hD0;
  localparam int POL_PRIV_BIT = 0;
  localparam int POL_PUB_BIT = 1;
  localparam int POL_TYPE_LSB = 2;
  localparam logic [2:0] KT_P256 = 3'h4;
  localparam logic [2:0] KT_NON_ECC = 3'h7;
  localparam int RK_EXT_BIT = 0;
  localparam int RK_TEMP_BIT = 1;
  localparam logic [3:0] NIB_VALID = 4'h5;
  localparam logic [3:0] NIB_INVALID = 4'hA;
  localparam logic [3:0] VCTL_FIRST_SLOT = 4'h8;
  localparam int CMD_SLOT_LSB = 0;
  localparam int CMD_OP_LSB = 4;
  localparam int CMD_TEMP_BIT = 8;
  localparam int CMD_RAND_BIT = 9;
  localparam int CMD_VAL_BIT = 10;
  localparam int CMD_SIGOK_BIT = 11;
  localparam int RES_ALLOWED = 0;
  localparam int RES_PUBOUT = 1;
  localparam int RES_VALID = 2;
  localparam int RES_VCTL = 3;
  localparam int RES_DONE = 4;
  localparam int EV_DONE = 0;
  localparam int EV_REFUSED = 1;
  localparam int NUM_EV = 2;
  localparam logic [15:0] POLICY_RST = 16'h001C;
  localparam logic [15:0] ACCESS_RST = 16'h0000;
  localparam logic [3:0] NIB_RST = NIB_INVALID;
  localparam logic [NUM_EV-1:0] IRQ_EN_RST = 2'h0;

  typedef enum logic [3:0] {
    OP_SIGN = 4'b0000,
    OP_KEYGEN = 4'b0001,
    OP_ECDH = 4'b0010,
    OP_PRIV_WRITE = 4'b0011,
    OP_VERIFY = 4'b0100,
    OP_MAC_CHECK = 4'b0101,
    OP_KEY_DERIVE = 4'b0110,
    OP_MAC = 4'b0111,
    OP_HMAC = 4'b1000,
    OP_DIGEST = 4'b1001,
    OP_SLOT_WRITE = 4'b1010,
    OP_INFO = 4'b1011
  } kspu_op_t;

  // Commands that belong to a private ECC slot
  function automatic logic is_priv_op(input kspu_op_t op);
    return (op == OP_SIGN) || (op == OP_KEYGEN) || (op == OP_ECDH) || (op == OP_PRIV_WRITE);
  endfunction

  function automatic logic is_sha_op(input kspu_op_t op);
    return (op == OP_MAC_CHECK) || (op == OP_KEY_DERIVE) || (op == OP_MAC) || (op == OP_HMAC);
  endfunction
endpackage

// [kspu_tb.sv]
// Self-checking bench for the key slot usage policy checker.
// Assumes the host model drives the register port; clock enable stays high except during the final interrupt clear check.
`timescale 1ns/100ps
module kspu_tb;
  import kspu_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [31:0] q;
  logic [4:0] i;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #4 sys_clk = ~sys_clk;

  kspu_top u_kspu_top (.sys_clk(sys_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

  kspu_host u_kspu_host (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_kspu_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_kspu_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  function automatic logic [7:0] slot_ofs(input logic [7:0] base, input logic [3:0] s);
    return base + {2'h0, s, 2'h0};
  endfunction

  task automatic pol(input logic [3:0] s, input logic [15:0] w);
    wr(slot_ofs(OFS_POLICY, s), {16'h0, w});
  endtask

  // Launch a command and compare the masked result word
  task automatic cmd(input logic [3:0] s, input logic [3:0] op, input logic [3:0] fl, input logic [4:0] e,
                     input logic [4:0] m);
    wr(OFS_CMD, {20'h0, fl, op, s});
    u_kspu_host.xfer(1'b0, OFS_RESULT, 32'h0, q);
    chk({27'h0, q[4:0] & m}, {27'h0, e & m});
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rdc(slot_ofs(OFS_POLICY, 4'h3), 32'h1C);
    rdc(slot_ofs(OFS_NIBBLE, 4'h9), 32'hA);
    rdc(OFS_IRQ_EN, 32'h0);
    rdc(OFS_IRQ_CLR, 32'h0);
    rdc(8'hD4, 32'h0);
    wr(slot_ofs(OFS_NIBBLE, 4'h9), 32'h5);
    rdc(slot_ofs(OFS_NIBBLE, 4'h9), 32'hA);
    wr(slot_ofs(OFS_ACCESS, 4'h2), 32'hFFFF_0003);
    rdc(slot_ofs(OFS_ACCESS, 4'h2), 32'h3);
    pol(4'h2, 16'h0013);
    for (i = 5'h00; i < 5'h10; i++) begin
      cmd(4'h2, i[3:0], 4'h0, {4'h0, i < 5'h04}, 5'h01);
    end
    pol(4'h3, 16'h001C);
    for (i = 5'h00; i < 5'h10; i++) begin
      cmd(4'h3, i[3:0], 4'h0, {4'h0, i > 5'h04 && i < 5'h0C}, 5'h01);
    end
    for (i = 5'h00; i < 5'h08; i++) begin
      pol(4'h2, {11'h0, i[2:0], 2'h3});
      cmd(4'h2, 4'h1, 4'h0, {4'h0, i == 5'h04}, 5'h01);
    end
    pol(4'h2, 16'h0011);
    cmd(4'h2, 4'h1, 4'h0, 5'h01, 5'h03);
    cmd(4'h2, 4'h1, 4'h2, 5'h03, 5'h03);
    pol(4'h2, 16'h0013);
    cmd(4'h2, 4'h1, 4'h0, 5'h03, 5'h03);
    for (i = 5'h01; i < 5'h03; i++) begin
      wr(slot_ofs(OFS_ACCESS, 4'h2), {27'h0, i});
      cmd(4'h2, 4'h0, 4'h0, {4'h0, i == 5'h01}, 5'h01);
      cmd(4'h2, 4'h0, 4'h1, {4'h0, i == 5'h02}, 5'h01);
    end
    pol(4'h9, 16'h0012);
    cmd(4'h9, 4'h4, 4'h0, 5'h08, 5'h09);
    cmd(4'h9, 4'h9, 4'h0, 5'h01, 5'h01);
    cmd(4'h9, 4'hB, 4'h0, 5'h01, 5'h05);
    cmd(4'h9, 4'h4, 4'h4, 5'h01, 5'h01);
    rdc(slot_ofs(OFS_NIBBLE, 4'h9), 32'hA);
    cmd(4'h9, 4'h4, 4'hC, 5'h01, 5'h01);
    rdc(slot_ofs(OFS_NIBBLE, 4'h9), 32'h5);
    cmd(4'h9, 4'h4, 4'h0, 5'h09, 5'h09);
    cmd(4'h9, 4'hB, 4'h0, 5'h05, 5'h05);
    cmd(4'h9, 4'h1, 4'h0, 5'h00, 5'h01);
    rdc(slot_ofs(OFS_NIBBLE, 4'h9), 32'h5);
    cmd(4'h9, 4'hA, 4'h0, 5'h01, 5'h01);
    rdc(slot_ofs(OFS_NIBBLE, 4'h9), 32'hA);
    pol(4'h3, 16'h0012);
    cmd(4'h3, 4'h4, 4'h0, 5'h01, 5'h09);
    pol(4'h9, 16'h0010);
    cmd(4'h9, 4'h4, 4'h0, 5'h01, 5'h09);
    // Interrupt path: raise, mask, clear
    chk({31'h0, irq}, 32'h0);
    rdc(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_EN, 32'h2);
    rdc(OFS_IRQ_EN, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLR, 32'h2);
    rdc(OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_EN, 32'h3);
    wr(OFS_IRQ_CLR, 32'h1);
    rdc(OFS_IRQ_STAT, 32'h0);
    cmd(4'h9, 4'h4, 4'h0, 5'h01, 5'h01);
    rdc(OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    // Clock enable low holds the pending clear and the interrupt
    ce <= 1'b0;
    fork
      wr(OFS_IRQ_CLR, 32'h3);
      begin
        repeat (4) @(posedge sys_clk);
        chk({30'h0, irq, avs_waitrequest}, 32'h3);
        ce <= 1'b1;
      end
    join
    rdc(OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    end_sim();
  end
endmodule

// [kspu_top.sv]
// Key slot usage policy checker with its register file, Avalon-MM slave and interrupt.
// Assumes an Avalon-MM master on sys_clk that holds each request until waitrequest is low.
`timescale 1ns/100ps
module kspu_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  import kspu_pkg::*;

  function automatic logic blk_hit(input logic [7:0] addr, input logic [7:0] base);
    return addr[7:6] == base[7:6];
  endfunction

  logic [15:0] policy [NUM_SLOTS];
  logic [15:0] access [NUM_SLOTS];
  logic [3:0] nibble [NUM_SLOTS];
  logic [SLOT_W-1:0] cmd_slot;
  kspu_op_t cmd_op;
  logic cmd_temp;
  logic cmd_rand;
  logic cmd_val;
  logic cmd_sigok;
  logic cmd_pend;
  logic res_allowed;
  logic res_pubout;
  logic res_valid;
  logic res_vctl;
  logic res_done;
  logic [NUM_EV-1:0] irq_status;
  logic [NUM_EV-1:0] irq_enable;
  logic [7:0] word_addr;
  logic [SLOT_W-1:0] addr_slot;
  logic wr_take;
  logic exec;
  logic [31:0] next_readdata;
  logic [NUM_EV-1:0] ev_set;
  logic [NUM_EV-1:0] ev_clr;

  kspu_chk_if chk (
    .clk(sys_clk),
    .srst(srst)
  );

  kspu_check u_check (
    .c(chk)
  );

  assign word_addr = {avs_address[7:2], 2'b00};
  assign addr_slot = avs_address[5:2];
  // A write lands only on the edge that also completes the bus handshake
  assign wr_take = ce && avs_write && !avs_waitrequest;
  assign exec = ce && cmd_pend;

  assign chk.policy = policy[cmd_slot];
  assign chk.read_key = access[cmd_slot][1:0];
  assign chk.slot = cmd_slot;
  assign chk.op = cmd_op;
  assign chk.temp_src = cmd_temp;
  assign chk.rand_gen = cmd_rand;
  assign chk.validate = cmd_val;
  assign chk.nibble = nibble[cmd_slot];

  // Bus handshake: one wait cycle, read data captured at the first edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h0;
    if (blk_hit(word_addr, OFS_POLICY)) begin
      next_readdata[15:0] = policy[addr_slot];
    end else if (blk_hit(word_addr, OFS_ACCESS)) begin
      next_readdata[15:0] = access[addr_slot];
    end else if (blk_hit(word_addr, OFS_NIBBLE)) begin
      next_readdata[3:0] = nibble[addr_slot];
    end else if (word_addr == OFS_CMD) begin
      next_readdata[CMD_SLOT_LSB +: SLOT_W] = cmd_slot;
      next_readdata[CMD_OP_LSB +: 4] = cmd_op;
      next_readdata[CMD_TEMP_BIT] = cmd_temp;
      next_readdata[CMD_RAND_BIT] = cmd_rand;
      next_readdata[CMD_VAL_BIT] = cmd_val;
      next_readdata[CMD_SIGOK_BIT] = cmd_sigok;
    end else if (word_addr == OFS_RESULT) begin
      next_readdata[RES_ALLOWED] = res_allowed;
      next_readdata[RES_PUBOUT] = res_pubout;
      next_readdata[RES_VALID] = res_valid;
      next_readdata[RES_VCTL] = res_vctl;
      next_readdata[RES_DONE] = res_done;
    end else if (word_addr == OFS_IRQ_STAT) begin
      next_readdata[NUM_EV-1:0] = irq_status;
    end else if (word_addr == OFS_IRQ_EN) begin
      next_readdata[NUM_EV-1:0] = irq_enable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if (ce && avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // Slot configuration words, software owned
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        policy[i] <= POLICY_RST;
        access[i] <= ACCESS_RST;
      end
    end else if (wr_take) begin
      if (blk_hit(word_addr, OFS_POLICY)) begin
        policy[addr_slot] <= avs_writedata[15:0];
      end
      if (blk_hit(word_addr, OFS_ACCESS)) begin
        access[addr_slot] <= avs_writedata[15:0];
      end
    end
  end

  // Command launch; the check runs in the cycle after the write lands
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_slot <= 4'h0;
      cmd_op <= OP_INFO;
      cmd_temp <= 1'b0;
      cmd_rand <= 1'b0;
      cmd_val <= 1'b0;
      cmd_sigok <= 1'b0;
      cmd_pend <= 1'b0;
    end else if (ce) begin
      cmd_pend <= 1'b0;
      if (wr_take && word_addr == OFS_CMD) begin
        cmd_slot <= avs_writedata[CMD_SLOT_LSB +: SLOT_W];
        cmd_op <= kspu_op_t'(avs_writedata[CMD_OP_LSB +: 4]);
        cmd_temp <= avs_writedata[CMD_TEMP_BIT];
        cmd_rand <= avs_writedata[CMD_RAND_BIT];
        cmd_val <= avs_writedata[CMD_VAL_BIT];
        cmd_sigok <= avs_writedata[CMD_SIGOK_BIT];
        cmd_pend <= 1'b1;
      end
    end
  end

  // Result of the last command as seen by the requester
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      res_allowed <= 1'b0;
      res_pubout <= 1'b0;
      res_valid <= 1'b0;
      res_vctl <= 1'b0;
      res_done <= 1'b0;
    end else if (exec) begin
      res_allowed <= chk.allowed;
      res_pubout <= chk.pub_out;
      res_valid <= chk.allowed && (cmd_op == OP_SIGN || cmd_op == OP_INFO) && chk.nib_valid;
      res_vctl <= chk.vctl;
      res_done <= 1'b1;
    end
  end

  // Validity nibbles; only permitted commands may touch them
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        nibble[i] <= NIB_RST;
      end
    end else if (exec && chk.allowed) begin
      if (cmd_op == OP_SLOT_WRITE && chk.vctl) begin
        nibble[cmd_slot] <= NIB_INVALID;
      end else if (cmd_op == OP_VERIFY && cmd_val && cmd_sigok && chk.vctl) begin
        nibble[cmd_slot] <= NIB_VALID;
      end
    end
  end

  // Interrupt: sticky events, write-one clear, set beats clear
  assign ev_set = exec ? {!chk.allowed, chk.allowed} : 2'h0;
  assign ev_clr = (wr_take && word_addr == OFS_IRQ_CLR) ? avs_writedata[NUM_EV-1:0] : 2'h0;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_status <= 2'h0;
    end else if (ce) begin
      irq_status <= (irq_status & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_enable <= IRQ_EN_RST;
    end else if (wr_take && word_addr == OFS_IRQ_EN) begin
      irq_enable <= avs_writedata[NUM_EV-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_status & irq_enable);
    end
  end

  a_inval_write: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.allowed && cmd_op == OP_SLOT_WRITE && chk.vctl |=> nibble[$past(cmd_slot)] == 4'hA)
    else $error("slot write did not invalidate key");
  a_validate: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.allowed && cmd_op == OP_VERIFY && cmd_val && cmd_sigok && chk.vctl
    |=> nibble[$past(cmd_slot)] == 4'h5) else $error("validating verify did not mark key valid");
  a_refused_keep: assert property (@(posedge sys_clk) disable iff (srst)
    exec && !chk.allowed |=> nibble[$past(cmd_slot)] == $past(chk.nibble))
    else $error("refused command changed validity");
  a_refused_event: assert property (@(posedge sys_clk) disable iff (srst)
    exec && !chk.allowed |=> irq_status[EV_REFUSED] && !res_allowed && res_done)
    else $error("refusal not reported");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (srst)
    ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (srst)
    ce |=> irq == |($past(irq_status) & $past(irq_enable))) else $error("interrupt level wrong");
  a_report_valid: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.allowed && cmd_op == OP_INFO |=> res_valid == ($past(chk.nibble) == 4'h5))
    else $error("validity report wrong");

  // Result word follows the decision of the command that ran
  a_res_allowed: assert property (@(posedge sys_clk) disable iff (srst)
    exec |=> res_allowed == $past(chk.allowed))
    else $error("allowed flag not reported");
  a_res_done: assert property (@(posedge sys_clk) disable iff (srst)
    exec |=> res_done)
    else $error("done flag not set after command");
  a_res_vctl: assert property (@(posedge sys_clk) disable iff (srst)
    exec |=> res_vctl == $past(chk.vctl))
    else $error("validity control flag not reported");
  a_pubout_copy: assert property (@(posedge sys_clk) disable iff (srst)
    exec |=> res_pubout == $past(chk.pub_out))
    else $error("public key output flag not reported");
  a_hidden_key: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_op == OP_KEYGEN && !cmd_rand && !chk.policy[POL_PUB_BIT] |=> !res_pubout)
    else $error("hidden public key was produced");
  a_rand_pub: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.allowed && cmd_op == OP_KEYGEN && cmd_rand |=> res_pubout)
    else $error("random key generation gave no public key");
  a_keygen_only: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_op != OP_KEYGEN |=> !res_pubout)
    else $error("public key output from a foreign command");
  a_sign_report: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.allowed && cmd_op == OP_SIGN |=> res_valid == ($past(chk.nibble) == 4'h5))
    else $error("sign validity report wrong");
  a_report_scope: assert property (@(posedge sys_clk) disable iff (srst)
    exec && !(cmd_op inside {OP_SIGN, OP_INFO}) |=> !res_valid)
    else $error("validity reported by a foreign command");
  a_res_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !exec |=> $stable(res_allowed) && $stable(res_valid) && $stable(res_pubout))
    else $error("result changed without a command");

  // Validity nibble moves only as the rules allow
  a_nib_idle: assert property (@(posedge sys_clk) disable iff (srst)
    !exec |=> nibble[$past(cmd_slot)] == $past(chk.nibble))
    else $error("validity changed without a command");
  a_nib_other: assert property (@(posedge sys_clk) disable iff (srst)
    exec && !(cmd_op inside {OP_SLOT_WRITE, OP_VERIFY}) |=> nibble[$past(cmd_slot)] == $past(chk.nibble))
    else $error("validity changed by a foreign command");
  a_low_slot: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_slot < 4'h8 |=> nibble[$past(cmd_slot)] == $past(chk.nibble))
    else $error("validity changed on a lower slot");
  a_priv_nib: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.policy[POL_PRIV_BIT] |=> nibble[$past(cmd_slot)] == $past(chk.nibble))
    else $error("validity changed on a private slot");
  a_unchecked_keep: assert property (@(posedge sys_clk) disable iff (srst)
    exec && !chk.policy[POL_PUB_BIT] |=> nibble[$past(cmd_slot)] == $past(chk.nibble))
    else $error("validity changed on an uncontrolled slot");
  a_verify_gate: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.allowed && cmd_op == OP_VERIFY && chk.vctl && !cmd_val |-> chk.nibble == 4'h5)
    else $error("verify used an unvalidated key");

  // Permission checks seen at the command level
  a_ecdh_type: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.allowed && cmd_op == OP_ECDH |-> chk.policy[POL_PRIV_BIT] && chk.policy[4:2] == 3'b100)
    else $error("key agreement allowed on a wrong slot");
  a_sha_error: assert property (@(posedge sys_clk) disable iff (srst)
    exec && is_sha_op(cmd_op) && chk.policy[POL_PRIV_BIT] |=> !res_allowed && irq_status[EV_REFUSED])
    else $error("hash command on private slot not refused");
  a_digest_priv: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_op == OP_DIGEST && chk.policy[POL_PRIV_BIT] |=> !res_allowed)
    else $error("digest allowed on a private slot");
  a_digest_free: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_op == OP_DIGEST && !chk.policy[POL_PRIV_BIT] |=> res_allowed)
    else $error("digest refused on a plain slot");
  a_private_key_write_cmd: assert property (@(posedge sys_clk) disable iff (srst)
    exec && cmd_op == OP_PRIV_WRITE |=> res_allowed == $past(chk.policy[POL_PRIV_BIT]))
    else $error("private write permission wrong");
  a_done_event: assert property (@(posedge sys_clk) disable iff (srst)
    exec && chk.allowed |=> irq_status[EV_DONE])
    else $error("completion event not raised");

  // Register writes and bus timing
  a_cfg_write: assert property (@(posedge sys_clk) disable iff (srst)
    wr_take && blk_hit(word_addr, OFS_POLICY) |=> policy[$past(addr_slot)] == $past(avs_writedata[15:0]))
    else $error("policy word write lost");
  a_acc_write: assert property (@(posedge sys_clk) disable iff (srst)
    wr_take && blk_hit(word_addr, OFS_ACCESS) |=> access[$past(addr_slot)] == $past(avs_writedata[15:0]))
    else $error("access word write lost");
  a_en_write: assert property (@(posedge sys_clk) disable iff (srst)
    wr_take && word_addr == OFS_IRQ_EN |=> irq_enable == $past(avs_writedata[NUM_EV-1:0]))
    else $error("interrupt enable write lost");
  a_cmd_launch: assert property (@(posedge sys_clk) disable iff (srst)
    wr_take && word_addr == OFS_CMD |=> cmd_pend && cmd_slot == $past(avs_writedata[CMD_SLOT_LSB +: SLOT_W]))
    else $error("command write did not launch");
  a_wait_idle: assert property (@(posedge sys_clk) disable iff (srst)
    ce && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_freeze: assert property (@(posedge sys_clk) disable iff (srst)
    !ce |=> $stable(avs_waitrequest) && $stable(avs_readdata) && $stable(irq) && $stable(irq_status))
    else $error("state moved while clock enable low");
  a_rd_launch: assert property (@(posedge sys_clk) disable iff (srst)
    ce && avs_read && avs_waitrequest |=> avs_readdata == $past(next_readdata))
    else $error("read data not captured");

  // Status bits: set beats clear, nothing sets without an event
  a_set_wins: assert property (@(posedge sys_clk) disable iff (srst)
    ce |=> (irq_status & $past(ev_set)) == $past(ev_set))
    else $error("event lost against a clear");
  a_clr_only: assert property (@(posedge sys_clk) disable iff (srst)
    !exec |=> (irq_status & ~$past(irq_status)) == 2'h0)
    else $error("status bit set without an event");
  a_clear_works: assert property (@(posedge sys_clk) disable iff (srst)
    ce && !exec |=> (irq_status & $past(ev_clr)) == 2'h0)
    else $error("status bit not cleared");
endmodule
